// ==== pkg/cdb_pkg.sv ====
// Constants, offsets and field layout of the core debug breakpoint unit.
// Assumes a tile with eight logical cores and a plain register port.
//
// Summary of operation
// - On debug entry write cause code: 1 host, 2 call, 3 ibp, 4 dwp, 5 rwp.
// - Record index of the hardware comparator that fired, lowest index wins.
// - Record the number of the causing core, zero when no core caused it.
// - Capture access address on data watch, resource id on resource watch.
// - Halt mask bits stop their cores whenever debug mode is not active.
// - A five bit operand selects the register the debug read returns.
// - Four instruction breakpoints compare their address with the program counter.
// - Each comparator has eight per-core enable bits, reset to zero.
// - Instruction breakpoint invert bit triggers on inequality instead.
// - Bit zero of each comparator control enables it, reset to zero.
// - Data watchpoints always trigger on stores, on loads only if enabled.
// - Normal range matches first limit to second limit, both inclusive.
// - Inverted range matches outside the open interval second to first.
// - Four data watchpoints each hold a first and a second limit address.
// - Resource watchpoint fires when masked resource id equals its value.
// - Resource watchpoint invert bit fires on inequality instead.
// - Eight scratch words shared with the tile configuration space.
// - An eight bit operand names the core whose state the debug read accesses.
// - On debug entry save the interrupted saved program counter.
package cdb_pkg;

  localparam int unsigned CDB_NUM_CORES = 8;
  localparam int unsigned CDB_CORE_ID_W = 3;
  localparam int unsigned CDB_NUM_CMP = 4;
  localparam int unsigned CDB_NUM_SCRATCH = 8;

  localparam logic [7:0] CDB_SAVED_PC_OFS = 8'h11;
  localparam logic [7:0] CDB_CORE_SEL_OFS = 8'h13;
  localparam logic [7:0] CDB_REG_SEL_OFS = 8'h14;
  localparam logic [7:0] CDB_CAUSE_OFS = 8'h15;
  localparam logic [7:0] CDB_CAPTURE_OFS = 8'h16;
  localparam logic [7:0] CDB_HALT_OFS = 8'h18;
  localparam logic [7:0] CDB_SCRATCH_OFS = 8'h20;
  localparam logic [7:0] CDB_IB_ADDR_OFS = 8'h30;
  localparam logic [7:0] CDB_IB_CTRL_OFS = 8'h40;
  localparam logic [7:0] CDB_DW_FIRST_OFS = 8'h50;
  localparam logic [7:0] CDB_DW_SECOND_OFS = 8'h60;
  localparam logic [7:0] CDB_DW_CTRL_OFS = 8'h70;
  localparam logic [7:0] CDB_RW_MASK_OFS = 8'h80;
  localparam logic [7:0] CDB_RW_VALUE_OFS = 8'h90;
  localparam logic [7:0] CDB_RW_CTRL_OFS = 8'h9c;

  localparam int unsigned CDB_EN_BIT = 0;
  localparam int unsigned CDB_INV_BIT = 1;
  localparam int unsigned CDB_LOAD_BIT = 2;
  localparam int unsigned CDB_CORE_EN_LSB = 16;
  localparam int unsigned CDB_CAUSE_IDX_LSB = 16;
  localparam int unsigned CDB_CAUSE_CORE_LSB = 8;

  localparam logic [2:0] CDB_CAUSE_NONE = 3'h0;
  localparam logic [2:0] CDB_CAUSE_HOST = 3'h1;
  localparam logic [2:0] CDB_CAUSE_CALL = 3'h2;
  localparam logic [2:0] CDB_CAUSE_IBP = 3'h3;
  localparam logic [2:0] CDB_CAUSE_DWP = 3'h4;
  localparam logic [2:0] CDB_CAUSE_RWP = 3'h5;

  localparam logic [31:0] CDB_RST_WORD = 32'h0;

  typedef enum logic {CDB_RUN, CDB_DEBUG} cdb_mode_e;

endpackage

// ==== hw/cdb_core_debug_unit.sv ====
// Debug register file, breakpoint and watchpoint comparators, debug mode.
// Assumes core observation inputs are synchronous single-cycle samples.
`timescale 1ns/1ps

module cdb_core_debug_unit
  import cdb_pkg::*;
#(
  parameter int unsigned NUM_CMP = CDB_NUM_CMP
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [31:0] cfg_rdata,
  input wire logic host_debug_req,
  input wire logic debug_call_instruction,
  input wire logic [CDB_CORE_ID_W-1:0] call_core,
  input wire logic pc_valid,
  input wire logic [CDB_CORE_ID_W-1:0] pc_core,
  input wire logic [31:0] pc,
  input wire logic mem_valid,
  input wire logic mem_store,
  input wire logic [CDB_CORE_ID_W-1:0] mem_core,
  input wire logic [31:0] mem_addr,
  input wire logic res_valid,
  input wire logic [CDB_CORE_ID_W-1:0] res_core,
  input wire logic [31:0] res_id,
  input wire logic [31:0] saved_program_counter,
  input wire logic debug_return,
  output logic debug_enter,
  output logic debug_mode,
  output logic [CDB_NUM_CORES-1:0] core_halt,
  output logic [7:0] debug_read_core_select,
  output logic [4:0] debug_read_core_register
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  cdb_mode_e mode_q;
  logic [31:0] saved_pc_q;
  logic [7:0] core_sel_q;
  logic [4:0] reg_sel_q;
  logic [2:0] cause_code_q;
  logic [1:0] cause_idx_q;
  logic [7:0] cause_core_q;
  logic [31:0] capture_q;
  logic [CDB_NUM_CORES-1:0] halt_q;
  logic [31:0] scratch_q [CDB_NUM_SCRATCH];
  logic [31:0] ib_addr_q [NUM_CMP], dw_first_q [NUM_CMP];
  logic [31:0] dw_second_q [NUM_CMP], rw_mask_q [NUM_CMP];
  logic [31:0] rw_value_q [NUM_CMP];
  logic [CDB_NUM_CORES-1:0] ib_cores_q [NUM_CMP], dw_cores_q [NUM_CMP];
  logic [CDB_NUM_CORES-1:0] rw_cores_q [NUM_CMP];
  logic [NUM_CMP-1:0] ib_en_q, ib_inv_q, dw_en_q, dw_inv_q;
  logic [NUM_CMP-1:0] dw_load_q, rw_en_q, rw_inv_q;

  logic [NUM_CMP-1:0] ib_hit, dw_hit, rw_hit;
  logic enter;
  logic [2:0] cause_d;
  logic [1:0] idx_d;
  logic [7:0] core_d;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers.

  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] b);
    in_bank = (a[7:2] == b[7:2]);
  endfunction

  logic wr_cause, wr_capture;
  assign wr_cause = reg_wr && (reg_addr == CDB_CAUSE_OFS);
  assign wr_capture = reg_wr && (reg_addr == CDB_CAPTURE_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Comparators, one set per index.

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++)
    begin : g_cmp
      logic in_range, out_range;
      assign ib_hit[gi] = pc_valid && ib_en_q[gi]
        && ib_cores_q[gi][pc_core]
        && ((pc == ib_addr_q[gi]) != ib_inv_q[gi]);
      assign in_range = (mem_addr >= dw_first_q[gi])
        && (mem_addr <= dw_second_q[gi]);
      assign out_range = (mem_addr <= dw_second_q[gi])
        || (mem_addr >= dw_first_q[gi]);
      assign dw_hit[gi] = mem_valid && dw_en_q[gi]
        && dw_cores_q[gi][mem_core]
        && (mem_store || dw_load_q[gi])
        && (dw_inv_q[gi] ? out_range : in_range);
      assign rw_hit[gi] = res_valid && rw_en_q[gi]
        && rw_cores_q[gi][res_core]
        && (((res_id & rw_mask_q[gi]) == rw_value_q[gi])
          != rw_inv_q[gi]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Cause selection: lowest cause code first, lowest index within a kind.

  function automatic logic [1:0] lowest(input logic [NUM_CMP-1:0] v);
    lowest = 2'h0;
    for (int k = NUM_CMP - 1; k >= 0; k--)
      if (v[k])
        lowest = k[1:0];
  endfunction

  always_comb
  begin
    cause_d = CDB_CAUSE_NONE;
    idx_d = 2'h0;
    core_d = 8'h00;
    if (host_debug_req)
      cause_d = CDB_CAUSE_HOST;
    else if (debug_call_instruction)
    begin
      cause_d = CDB_CAUSE_CALL;
      core_d = {5'h00, call_core};
    end
    else if (|ib_hit)
    begin
      cause_d = CDB_CAUSE_IBP;
      idx_d = lowest(ib_hit);
      core_d = {5'h00, pc_core};
    end
    else if (|dw_hit)
    begin
      cause_d = CDB_CAUSE_DWP;
      idx_d = lowest(dw_hit);
      core_d = {5'h00, mem_core};
    end
    else if (|rw_hit)
    begin
      cause_d = CDB_CAUSE_RWP;
      idx_d = lowest(rw_hit);
      core_d = {5'h00, res_core};
    end
  end

  assign enter = (mode_q == CDB_RUN) && (cause_d != CDB_CAUSE_NONE);
  assign debug_enter = enter;
  assign debug_mode = (mode_q == CDB_DEBUG);
  assign core_halt = debug_mode ? '0 : halt_q;
  assign debug_read_core_select = core_sel_q;
  assign debug_read_core_register = reg_sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Debug mode state.

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      mode_q <= CDB_RUN;
    else
      case (mode_q)
        CDB_RUN:
          if (enter)
            mode_q <= CDB_DEBUG;
        CDB_DEBUG:
          if (debug_return)
            mode_q <= CDB_RUN;
        default: mode_q <= CDB_RUN;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event record: entry wins over a software write in the same cycle.

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cause_code_q <= CDB_CAUSE_NONE;
      cause_idx_q <= 2'h0;
      cause_core_q <= 8'h00;
      capture_q <= CDB_RST_WORD;
      saved_pc_q <= CDB_RST_WORD;
    end
    else if (enter)
    begin
      cause_code_q <= cause_d;
      cause_idx_q <= idx_d;
      cause_core_q <= core_d;
      saved_pc_q <= saved_program_counter;
      if (cause_d == CDB_CAUSE_DWP)
        capture_q <= mem_addr;
      else if (cause_d == CDB_CAUSE_RWP)
        capture_q <= res_id;
    end
    else
    begin
      if (wr_cause)
      begin
        cause_code_q <= reg_wdata[2:0];
        cause_idx_q <= reg_wdata[CDB_CAUSE_IDX_LSB+:2];
        cause_core_q <= reg_wdata[CDB_CAUSE_CORE_LSB+:8];
      end
      if (wr_capture)
        capture_q <= reg_wdata;
      if (reg_wr && (reg_addr == CDB_SAVED_PC_OFS))
        saved_pc_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operands and halt mask.

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      core_sel_q <= 8'h00;
      reg_sel_q <= 5'h00;
      halt_q <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == CDB_CORE_SEL_OFS)
        core_sel_q <= reg_wdata[7:0];
      if (reg_addr == CDB_REG_SEL_OFS)
        reg_sel_q <= reg_wdata[4:0];
      if (reg_addr == CDB_HALT_OFS)
        halt_q <= reg_wdata[CDB_NUM_CORES-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scratch words, reachable from both ports; the debug port wins a tie.

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      for (int k = 0; k < CDB_NUM_SCRATCH; k++)
        scratch_q[k] <= CDB_RST_WORD;
    else
    begin
      if (cfg_wr && (cfg_addr[7:3] == CDB_SCRATCH_OFS[7:3]))
        scratch_q[cfg_addr[2:0]] <= cfg_wdata;
      if (reg_wr && (reg_addr[7:3] == CDB_SCRATCH_OFS[7:3]))
        scratch_q[reg_addr[2:0]] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator registers.

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int k = 0; k < NUM_CMP; k++)
      begin
        ib_addr_q[k] <= CDB_RST_WORD;
        dw_first_q[k] <= CDB_RST_WORD;
        dw_second_q[k] <= CDB_RST_WORD;
        rw_mask_q[k] <= CDB_RST_WORD;
        rw_value_q[k] <= CDB_RST_WORD;
        ib_cores_q[k] <= '0;
        dw_cores_q[k] <= '0;
        rw_cores_q[k] <= '0;
      end
      ib_en_q <= '0;
      ib_inv_q <= '0;
      dw_en_q <= '0;
      dw_inv_q <= '0;
      dw_load_q <= '0;
      rw_en_q <= '0;
      rw_inv_q <= '0;
    end
    else if (reg_wr)
    begin
      if (in_bank(reg_addr, CDB_IB_ADDR_OFS))
        ib_addr_q[reg_addr[1:0]] <= reg_wdata;
      if (in_bank(reg_addr, CDB_IB_CTRL_OFS))
      begin
        ib_cores_q[reg_addr[1:0]] <=
          reg_wdata[CDB_CORE_EN_LSB+:CDB_NUM_CORES];
        ib_inv_q[reg_addr[1:0]] <= reg_wdata[CDB_INV_BIT];
        ib_en_q[reg_addr[1:0]] <= reg_wdata[CDB_EN_BIT];
      end
      if (in_bank(reg_addr, CDB_DW_FIRST_OFS))
        dw_first_q[reg_addr[1:0]] <= reg_wdata;
      if (in_bank(reg_addr, CDB_DW_SECOND_OFS))
        dw_second_q[reg_addr[1:0]] <= reg_wdata;
      if (in_bank(reg_addr, CDB_DW_CTRL_OFS))
      begin
        dw_cores_q[reg_addr[1:0]] <=
          reg_wdata[CDB_CORE_EN_LSB+:CDB_NUM_CORES];
        dw_load_q[reg_addr[1:0]] <= reg_wdata[CDB_LOAD_BIT];
        dw_inv_q[reg_addr[1:0]] <= reg_wdata[CDB_INV_BIT];
        dw_en_q[reg_addr[1:0]] <= reg_wdata[CDB_EN_BIT];
      end
      if (in_bank(reg_addr, CDB_RW_MASK_OFS))
        rw_mask_q[reg_addr[1:0]] <= reg_wdata;
      if (in_bank(reg_addr, CDB_RW_VALUE_OFS))
        rw_value_q[reg_addr[1:0]] <= reg_wdata;
      if (in_bank(reg_addr, CDB_RW_CTRL_OFS))
      begin
        rw_cores_q[reg_addr[1:0]] <=
          reg_wdata[CDB_CORE_EN_LSB+:CDB_NUM_CORES];
        rw_inv_q[reg_addr[1:0]] <= reg_wdata[CDB_INV_BIT];
        rw_en_q[reg_addr[1:0]] <= reg_wdata[CDB_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe; unmapped reads give zero.

  logic [31:0] rd_mux;
  logic [1:0] ri;
  assign ri = reg_addr[1:0];
  always_comb
  begin
    rd_mux = CDB_RST_WORD;
    if (reg_addr[7:3] == CDB_SCRATCH_OFS[7:3])
      rd_mux = scratch_q[reg_addr[2:0]];
    else if (in_bank(reg_addr, CDB_IB_ADDR_OFS))
      rd_mux = ib_addr_q[ri];
    else if (in_bank(reg_addr, CDB_IB_CTRL_OFS))
    begin
      rd_mux[CDB_CORE_EN_LSB+:CDB_NUM_CORES] = ib_cores_q[ri];
      rd_mux[CDB_INV_BIT] = ib_inv_q[ri];
      rd_mux[CDB_EN_BIT] = ib_en_q[ri];
    end
    else if (in_bank(reg_addr, CDB_DW_FIRST_OFS))
      rd_mux = dw_first_q[ri];
    else if (in_bank(reg_addr, CDB_DW_SECOND_OFS))
      rd_mux = dw_second_q[ri];
    else if (in_bank(reg_addr, CDB_DW_CTRL_OFS))
    begin
      rd_mux[CDB_CORE_EN_LSB+:CDB_NUM_CORES] = dw_cores_q[ri];
      rd_mux[CDB_LOAD_BIT] = dw_load_q[ri];
      rd_mux[CDB_INV_BIT] = dw_inv_q[ri];
      rd_mux[CDB_EN_BIT] = dw_en_q[ri];
    end
    else if (in_bank(reg_addr, CDB_RW_MASK_OFS))
      rd_mux = rw_mask_q[ri];
    else if (in_bank(reg_addr, CDB_RW_VALUE_OFS))
      rd_mux = rw_value_q[ri];
    else if (in_bank(reg_addr, CDB_RW_CTRL_OFS))
    begin
      rd_mux[CDB_CORE_EN_LSB+:CDB_NUM_CORES] = rw_cores_q[ri];
      rd_mux[CDB_INV_BIT] = rw_inv_q[ri];
      rd_mux[CDB_EN_BIT] = rw_en_q[ri];
    end
    else
    begin
      case (reg_addr)
        CDB_SAVED_PC_OFS: rd_mux = saved_pc_q;
        CDB_CORE_SEL_OFS: rd_mux[7:0] = core_sel_q;
        CDB_REG_SEL_OFS: rd_mux[4:0] = reg_sel_q;
        CDB_CAUSE_OFS:
        begin
          rd_mux[CDB_CAUSE_IDX_LSB+:2] = cause_idx_q;
          rd_mux[CDB_CAUSE_CORE_LSB+:8] = cause_core_q;
          rd_mux[2:0] = cause_code_q;
        end
        CDB_CAPTURE_OFS: rd_mux = capture_q;
        CDB_HALT_OFS: rd_mux[CDB_NUM_CORES-1:0] = halt_q;
        default: rd_mux = CDB_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      reg_rdata <= CDB_RST_WORD;
    else
      reg_rdata <= reg_rd ? rd_mux : CDB_RST_WORD;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cfg_rdata <= CDB_RST_WORD;
    else if (cfg_rd && (cfg_addr[7:3] == CDB_SCRATCH_OFS[7:3]))
      cfg_rdata <= scratch_q[cfg_addr[2:0]];
    else
      cfg_rdata <= CDB_RST_WORD;
  end

endmodule

// ==== verification/cdb_chk.sv ====
// Concurrent checks on the ports of the core debug breakpoint unit.
// Bound to every instance of the unit; sees only its top-level ports.
`timescale 1ns/1ps

module cdb_chk
  import cdb_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic host_debug_req,
  input wire logic debug_call_instruction,
  input wire logic pc_valid,
  input wire logic mem_valid,
  input wire logic res_valid,
  input wire logic debug_return,
  input wire logic debug_enter,
  input wire logic debug_mode,
  input wire logic [CDB_NUM_CORES-1:0] core_halt
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_host_entry;
    host_debug_req && debug_enter;
  endsequence

  sequence s_cause_read;
    reg_rd && reg_addr == CDB_CAUSE_OFS;
  endsequence

  sequence s_leave;
    debug_mode && debug_return;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_host_entry: assert property (
    host_debug_req && !debug_mode |-> debug_enter)
    else $error("host request not taken");
  a_call_entry: assert property (
    debug_call_instruction && !debug_mode |-> debug_enter)
    else $error("debug call not taken");
  a_entry_run: assert property (
    debug_enter |-> !debug_mode ##1 debug_mode)
    else $error("entry outside run mode or mode not set");
  a_no_trigger: assert property (
    !(host_debug_req || debug_call_instruction || pc_valid || mem_valid
      || res_valid) |-> !debug_enter)
    else $error("entry without any cause");
  a_halt_debug: assert property (
    debug_mode |-> core_halt == '0)
    else $error("cores halted while in debug mode");
  a_halt_run: assert property (
    !debug_mode && $past(!debug_mode) && !$past(reg_wr) |->
      $stable(core_halt))
    else $error("halt vector moved without a write");
  a_mode_hold: assert property (
    debug_mode && !debug_return |=> debug_mode)
    else $error("debug mode left without return");
  a_mode_leave: assert property (
    s_leave |=> !debug_mode)
    else $error("debug mode kept after return");
  a_host_cause: assert property (
    s_host_entry ##1 s_cause_read |=>
      reg_rdata[2:0] == CDB_CAUSE_HOST && reg_rdata[15:8] == 8'h0)
    else $error("host cause word wrong");
endmodule

bind cdb_core_debug_unit cdb_chk u_chk (.clock, .rst, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .host_debug_req, .debug_call_instruction, .pc_valid,
  .mem_valid, .res_valid, .debug_return, .debug_enter, .debug_mode,
  .core_halt);

// ==== verification/cdb_core_model.sv ====
// Processor core model: fetches, memory and resource accesses, debug calls.
// Assumes the debug unit's clock and its entry and mode outputs.
`timescale 1ns/1ps

module cdb_core_model
  import cdb_pkg::*;
(
  input wire logic clock,
  input wire logic debug_enter,
  input wire logic debug_mode,
  output logic debug_call_instruction,
  output logic [CDB_CORE_ID_W-1:0] call_core,
  output logic pc_valid,
  output logic [CDB_CORE_ID_W-1:0] pc_core,
  output logic [31:0] pc,
  output logic mem_valid,
  output logic mem_store,
  output logic [CDB_CORE_ID_W-1:0] mem_core,
  output logic [31:0] mem_addr,
  output logic res_valid,
  output logic [CDB_CORE_ID_W-1:0] res_core,
  output logic [31:0] res_id,
  output logic [31:0] saved_program_counter,
  output logic debug_return
);
  int ret_wait = 1;
  int wait_q = 0;

  initial
  begin
    {debug_call_instruction, res_valid, mem_valid, pc_valid} = 4'h0;
    {pc_core, mem_core, res_core, call_core} = '0;
    {pc, mem_addr, res_id, saved_program_counter} = '0;
    mem_store = 1'b0;
  end

  // The debug routine stays a programmable number of cycles, then returns.
  always @(posedge clock)
  begin
    debug_return <= 1'b0;
    if (debug_mode && !debug_return)
    begin
      wait_q <= wait_q + 1;
      if (wait_q + 1 >= ret_wait)
      begin
        debug_return <= 1'b1;
        wait_q <= 0;
      end
    end
  end

  // One event for one cycle: 0 fetch, 1 memory, 2 resource, 3 debug call.
  // Released data lines carry the inverse so stale values never match.
  task automatic ev(input int k, input logic s, input logic [2:0] c,
    input logic [31:0] d, output logic hit);
    int n;
    n = 0;
    #1;
    while (debug_mode && n < 100)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    {debug_call_instruction, res_valid, mem_valid, pc_valid} <= 4'h1 << k;
    {pc_core, mem_core, res_core, call_core} <= {4{c}};
    {pc, mem_addr, res_id} <= {3{d}};
    mem_store <= s;
    saved_program_counter <= ~d;
    #1;
    hit = debug_enter;
    @(posedge clock);
    {debug_call_instruction, res_valid, mem_valid, pc_valid} <= 4'h0;
    {pc, mem_addr, res_id} <= {3{~d}};
  endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the core debug breakpoint unit.
// Assumes the core model drives the event side; the bench owns both ports.
`timescale 1ns/1ps

module tb_top
  import cdb_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h0, cfg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, cfg_wdata = 32'h0, reg_rdata, cfg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic host_debug_req = 1'b0;
  logic debug_call_instruction, pc_valid, mem_valid, mem_store, res_valid;
  logic debug_return, debug_enter, debug_mode;
  logic [2:0] call_core, pc_core, mem_core, res_core;
  logic [31:0] pc, mem_addr, res_id, saved_program_counter;
  logic [7:0] core_halt, debug_read_core_select;
  logic [4:0] debug_read_core_register;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  always #2.5 clock = ~clock;

  cdb_core_debug_unit #(.NUM_CMP(4)) dut (.clock, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cfg_addr, .cfg_wdata, .cfg_wr,
    .cfg_rd, .cfg_rdata, .host_debug_req, .debug_call_instruction,
    .call_core, .pc_valid, .pc_core, .pc, .mem_valid, .mem_store, .mem_core,
    .mem_addr, .res_valid, .res_core, .res_id, .saved_program_counter,
    .debug_return, .debug_enter, .debug_mode, .core_halt,
    .debug_read_core_select, .debug_read_core_register);

  cdb_core_model core (.clock, .debug_enter, .debug_mode,
    .debug_call_instruction, .call_core, .pc_valid, .pc_core, .pc,
    .mem_valid, .mem_store, .mem_core, .mem_addr, .res_valid, .res_core,
    .res_id, .saved_program_counter, .debug_return);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Port select p: 0 debug register port, 1 tile configuration port.
  task automatic wr(input logic p, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {reg_addr, cfg_addr} <= {a, a};
    {reg_wdata, cfg_wdata} <= {d, d};
    {reg_wr, cfg_wr} <= {!p, p};
    @(posedge clock);
    {reg_wr, cfg_wr} <= 2'b00;
  endtask

  task automatic rd(input logic p, input logic [7:0] a, input logic [31:0] e,
    input string nm);
    @(posedge clock);
    {reg_addr, cfg_addr} <= {a, a};
    {reg_rd, cfg_rd} <= {!p, p};
    @(posedge clock);
    {reg_rd, cfg_rd} <= 2'b00;
    #1;
    chk(nm, e, p ? cfg_rdata : reg_rdata);
  endtask

  task automatic evc(input int k, input logic s, input logic [2:0] c,
    input logic [31:0] d, input logic e, input string nm);
    logic h;
    core.ev(k, s, c, d, h);
    chk(nm, {31'h0, e}, {31'h0, h});
  endtask

  task automatic idle();
    int n;
    n = 0;
    #1;
    while (debug_mode && n < 100)
    begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(0, CDB_CAUSE_OFS, 32'h0, "cause reset");
    for (int i = 0; i < 4; i++)
    begin
      rd(0, CDB_IB_CTRL_OFS + 8'(i), 32'h0, "ib ctrl reset");
      rd(0, CDB_DW_CTRL_OFS + 8'(i), 32'h0, "dw ctrl reset");
      rd(0, CDB_RW_CTRL_OFS + 8'(i), 32'h0, "rw ctrl reset");
    end
  endtask

  task automatic t_regs();
    wr(0, CDB_REG_SEL_OFS, 32'hffff_ffff);
    rd(0, CDB_REG_SEL_OFS, 32'h1f, "reg select");
    chk("reg select pins", 32'h1f, 32'(debug_read_core_register));
    wr(0, CDB_CORE_SEL_OFS, 32'hffff_ffa5);
    rd(0, CDB_CORE_SEL_OFS, 32'ha5, "core select");
    chk("core select pins", 32'ha5, 32'(debug_read_core_select));
    for (int i = 0; i < 8; i++)
    begin
      wr(i[0], CDB_SCRATCH_OFS + 8'(i), 32'hc0de_0000 + 32'(i));
      rd(!i[0], CDB_SCRATCH_OFS + 8'(i), 32'hc0de_0000 + 32'(i), "scr");
    end
    wr(1, 8'h30, 32'hdead_beef);
    rd(1, 8'h30, 32'h0, "cfg unmapped");
  endtask

  task automatic t_ibp();
    wr(0, CDB_IB_ADDR_OFS + 8'h1, 32'h0000_4000);
    wr(0, CDB_IB_ADDR_OFS + 8'h2, 32'h0000_4000);
    wr(0, CDB_IB_CTRL_OFS + 8'h2, 32'h0008_0001);
    evc(0, 0, 3'h2, 32'h4000, 0, "ib other core");
    evc(0, 0, 3'h3, 32'h4004, 0, "ib other pc");
    evc(0, 0, 3'h3, 32'h4000, 1, "ib hit");
    rd(0, CDB_CAUSE_OFS, 32'h0002_0303, "ib cause");
    rd(0, CDB_SAVED_PC_OFS, 32'hffff_bfff, "saved pc");
    wr(0, CDB_IB_CTRL_OFS + 8'h1, 32'h0008_0001);
    evc(0, 0, 3'h3, 32'h4000, 1, "ib two hits");
    rd(0, CDB_CAUSE_OFS, 32'h0001_0303, "ib lowest");
    wr(0, CDB_IB_CTRL_OFS + 8'h1, 32'h0008_0000);
    wr(0, CDB_IB_CTRL_OFS + 8'h2, 32'h0008_0003);
    evc(0, 0, 3'h3, 32'h4000, 0, "ib inv equal");
    evc(0, 0, 3'h3, 32'h4008, 1, "ib inv differ");
    rd(0, CDB_CAUSE_OFS, 32'h0002_0303, "ib inv cause");
    wr(0, CDB_IB_CTRL_OFS + 8'h2, 32'h0);
  endtask

  task automatic t_dwp();
    wr(0, CDB_DW_FIRST_OFS, 32'h100);
    wr(0, CDB_DW_SECOND_OFS, 32'h1ff);
    wr(0, CDB_DW_CTRL_OFS, 32'h0002_0001);
    evc(1, 1, 3'h1, 32'h100, 1, "dw low");
    rd(0, CDB_CAPTURE_OFS, 32'h100, "dw capture");
    rd(0, CDB_CAUSE_OFS, 32'h0000_0104, "dw cause");
    evc(1, 1, 3'h1, 32'h1ff, 1, "dw high");
    evc(1, 1, 3'h1, 32'h200, 0, "dw above");
    evc(1, 1, 3'h1, 32'h0ff, 0, "dw below");
    evc(1, 1, 3'h2, 32'h150, 0, "dw core");
    evc(1, 0, 3'h1, 32'h150, 0, "dw load off");
    wr(0, CDB_DW_CTRL_OFS, 32'h0002_0005);
    evc(1, 0, 3'h1, 32'h150, 1, "dw load on");
    wr(0, CDB_DW_CTRL_OFS, 32'h0);
    wr(0, CDB_DW_FIRST_OFS, 32'h200);
    wr(0, CDB_DW_SECOND_OFS, 32'h0ff);
    wr(0, CDB_DW_CTRL_OFS, 32'h0002_0003);
    evc(1, 1, 3'h1, 32'h0ff, 1, "dw inv second");
    evc(1, 1, 3'h1, 32'h200, 1, "dw inv first");
    evc(1, 1, 3'h1, 32'h100, 0, "dw inv in low");
    evc(1, 1, 3'h1, 32'h1ff, 0, "dw inv in high");
    wr(0, CDB_DW_CTRL_OFS, 32'h0);
  endtask

  task automatic t_rwp();
    wr(0, CDB_RW_MASK_OFS + 8'h1, 32'h0000_ff00);
    wr(0, CDB_RW_VALUE_OFS + 8'h1, 32'h0000_1200);
    wr(0, CDB_RW_CTRL_OFS + 8'h1, 32'h0001_0001);
    evc(2, 0, 3'h0, 32'h00ab_13cd, 0, "rw differ");
    evc(2, 0, 3'h0, 32'h00ab_12cd, 1, "rw equal");
    rd(0, CDB_CAPTURE_OFS, 32'h00ab_12cd, "rw capture");
    rd(0, CDB_CAUSE_OFS, 32'h0001_0005, "rw cause");
    wr(0, CDB_RW_CTRL_OFS + 8'h1, 32'h0001_0003);
    evc(2, 0, 3'h0, 32'h00ab_12cd, 0, "rw inv equal");
    evc(2, 0, 3'h0, 32'h00ab_13cd, 1, "rw inv differ");
    wr(0, CDB_RW_CTRL_OFS + 8'h1, 32'h0);
  endtask

  task automatic t_host();
    idle();
    @(posedge clock);
    host_debug_req <= 1'b1;
    @(posedge clock);
    host_debug_req <= 1'b0;
    reg_addr <= CDB_CAUSE_OFS;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("host cause", 32'h1, reg_rdata);
  endtask

  task automatic t_call_halt();
    evc(3, 0, 3'h5, 32'h0, 1, "call taken");
    rd(0, CDB_CAUSE_OFS, 32'h0000_0502, "call cause");
    idle();
    wr(0, CDB_HALT_OFS, 32'hffff_ff05);
    rd(0, CDB_HALT_OFS, 32'h05, "halt reg");
    chk("halt run", 32'h05, 32'(core_halt));
    core.ret_wait = 8;
    t_host();
    chk("halt debug", 32'h0, 32'(core_halt));
    idle();
    chk("halt after", 32'h05, 32'(core_halt));
    core.ret_wait = 1;
    wr(0, CDB_HALT_OFS, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_ibp();
    t_dwp();
    t_rwp();
    t_call_halt();
    idle();
    report_and_stop();
  end
endmodule
